// ---- pkg/aui_pkg.sv ----
// Shared constants and carrier types for the alarm and update interrupt block.
`default_nettype none
package aui_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_MINUTES = 8'h01;
  localparam logic [7:0] ADDR_HOURS = 8'h02;
  localparam logic [7:0] ADDR_WEEKDAY = 8'h03;
  localparam logic [7:0] ADDR_DATE = 8'h04;
  localparam logic [7:0] ADDR_ALM_MIN = 8'h08;
  localparam logic [7:0] ADDR_ALM_HOUR = 8'h09;
  localparam logic [7:0] ADDR_ALM_DAY = 8'h0a;
  localparam logic [7:0] ADDR_EXT_CFG = 8'h0d;
  localparam logic [7:0] ADDR_FLAGS = 8'h0e;
  localparam logic [7:0] ADDR_CTRL = 8'h0f;

  // Field positions.
  localparam int ALM_EXCLUDE_BIT = 7;
  localparam int EXT_TARGET_BIT = 6;
  localparam int EXT_UPD_SEL_BIT = 5;
  localparam int FLAG_UPD_BIT = 5;
  localparam int FLAG_ALM_BIT = 3;
  localparam int CTRL_UPD_IRQ_EN_BIT = 5;
  localparam int CTRL_ALM_IRQ_EN_BIT = 3;
  localparam int CTRL_STOP_BIT = 1;

  // Writable bit masks and reset values.
  localparam logic [7:0] EXT_WR_MASK = 8'h7f;
  localparam logic [7:0] CTRL_WR_MASK = 8'h7a;
  localparam logic [7:0] ALM_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Timing.
  localparam real CLOCK_PERIOD_NS = 4.0;
  localparam real IRQ_RELEASE_MS = 7.8;
  localparam int IRQ_RELEASE_CYC = $rtoi(IRQ_RELEASE_MS * 1.0e6 / CLOCK_PERIOD_NS);
  localparam int TK_CLOCK_PER_SEC = 32768;
  localparam int CNT_W = 24;

  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] weekday;
    logic [7:0] date;
  } aui_cal_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aui_reg_req_t;

  typedef struct packed {
    logic [7:0] almMin;
    logic [7:0] almHour;
    logic [7:0] almDay;
    logic [7:0] ext;
    logic [7:0] ctrl;
    logic alarmFlag;
    logic updateFlag;
    logic updActive;
    logic [CNT_W-1:0] updCnt;
    aui_cal_t calPrev;
    logic calValid;
    logic [2:0] secSync;
    logic irqOeN;
    logic [7:0] rdData;
  } aui_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] divCnt;
    logic secTgl;
  } aui_tk_state_t;

endpackage
`default_nettype wire

// ---- core/aui_core.sv ----
// Alarm and time update interrupt logic with its registers and open-drain interrupt pin.
`timescale 1ns/1ps
`default_nettype none
module aui_core #(
  parameter int unsigned IrqReleaseCyc = aui_pkg::IRQ_RELEASE_CYC,
  parameter int unsigned TkClockPerSec = aui_pkg::TK_CLOCK_PER_SEC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tkClock,
  input wire aui_pkg::aui_cal_t calNow,
  input wire aui_pkg::aui_reg_req_t regReq,
  output logic [7:0] regRdData,
  input wire logic irqIn,
  output logic irqOut,
  output logic irqOutEn_n
);
  import aui_pkg::*;

  localparam logic [CNT_W-1:0] RelLast = CNT_W'(IrqReleaseCyc - 1);
  localparam logic [CNT_W-1:0] DivLast = CNT_W'(TkClockPerSec - 1);

  aui_state_t s_q;
  aui_state_t s_d;
  aui_tk_state_t tk_q;
  aui_tk_state_t tk_d;

  logic secTick;
  logic calMoved;
  logic minMoved;
  logic stopped;
  logic alarmEvt;
  logic updEvt;
  logic wrFlags;
  logic wrCtrl;
  logic alarmFlagNext;
  logic updateFlagNext;
  logic alarmIrqEnNext;
  logic updateIrqEnNext;
  logic [7:0] ctrlNext;

  // Compares the alarm fields with the calendar, honouring exclusion and target select.
  function automatic logic alarmMatch(
    input logic [7:0] almMin,
    input logic [7:0] almHour,
    input logic [7:0] almDay,
    input logic dateMode,
    input aui_cal_t cal
  );
    logic minOk;
    logic hourOk;
    logic dayOk;
    minOk = almMin[ALM_EXCLUDE_BIT] || (almMin[6:0] == cal.minutes[6:0]);
    hourOk = almHour[ALM_EXCLUDE_BIT] || (almHour[5:0] == cal.hours[5:0]);
    if (almDay[ALM_EXCLUDE_BIT]) begin
      dayOk = 1'b1;
    end else if (dateMode) begin
      dayOk = (almDay[5:0] == cal.date[5:0]);
    end else begin
      dayOk = |(almDay[6:0] & cal.weekday[6:0]);
    end
    return minOk && hourOk && dayOk;
  endfunction

  // The free-running 1 Hz divider lives on the timekeeping clock and flips a toggle each second.
  always_comb begin
    tk_d = tk_q;
    if (tk_q.divCnt >= DivLast) begin
      tk_d.divCnt = '0;
      tk_d.secTgl = ~tk_q.secTgl;
    end else begin
      tk_d.divCnt = tk_q.divCnt + CNT_W'(1);
    end
  end

  always_ff @(posedge tkClock or negedge arst_n) begin
    if (!arst_n) begin
      tk_q <= '0;
    end else begin
      tk_q <= tk_d;
    end
  end

  // Events on the system clock.
  assign secTick = s_q.secSync[1] ^ s_q.secSync[2];
  assign calMoved = s_q.calValid && (calNow != s_q.calPrev);
  assign minMoved = s_q.calValid && (calNow.minutes != s_q.calPrev.minutes);
  assign stopped = s_q.ctrl[CTRL_STOP_BIT];
  assign alarmEvt = calMoved && !stopped &&
    alarmMatch(s_q.almMin, s_q.almHour, s_q.almDay, s_q.ext[EXT_TARGET_BIT], calNow);
  assign updEvt = !stopped && (s_q.ext[EXT_UPD_SEL_BIT] ? minMoved : secTick);

  // Register write decoding.
  assign wrFlags = regReq.wr && (regReq.addr == ADDR_FLAGS);
  assign wrCtrl = regReq.wr && (regReq.addr == ADDR_CTRL);
  assign ctrlNext = wrCtrl ? (regReq.wdata & CTRL_WR_MASK) : s_q.ctrl;
  assign alarmIrqEnNext = ctrlNext[CTRL_ALM_IRQ_EN_BIT];
  assign updateIrqEnNext = ctrlNext[CTRL_UPD_IRQ_EN_BIT];
  // A set in the same cycle as a clear wins; writing 1 leaves a flag unchanged.
  assign alarmFlagNext = alarmEvt ||
    (s_q.alarmFlag && !(wrFlags && !regReq.wdata[FLAG_ALM_BIT]));
  assign updateFlagNext = updEvt ||
    (s_q.updateFlag && !(wrFlags && !regReq.wdata[FLAG_UPD_BIT]));

  always_comb begin
    s_d = s_q;
    s_d.secSync = {s_q.secSync[1:0], tk_q.secTgl};
    s_d.calPrev = calNow;
    s_d.calValid = 1'b1;
    s_d.alarmFlag = alarmFlagNext;
    s_d.updateFlag = updateFlagNext;
    s_d.ctrl = ctrlNext;
    if (regReq.wr) begin
      unique case (regReq.addr)
        ADDR_ALM_MIN: begin
          s_d.almMin = regReq.wdata;
        end
        ADDR_ALM_HOUR: begin
          s_d.almHour = regReq.wdata;
        end
        ADDR_ALM_DAY: begin
          s_d.almDay = regReq.wdata;
        end
        ADDR_EXT_CFG: begin
          s_d.ext = regReq.wdata & EXT_WR_MASK;
        end
        default: begin
        end
      endcase
    end
    // The update pulse restarts on each enabled event and ends by timeout or by cancel.
    if (updEvt && updateIrqEnNext) begin
      s_d.updActive = 1'b1;
      s_d.updCnt = '0;
    end else if (!updateFlagNext || !updateIrqEnNext) begin
      s_d.updActive = 1'b0;
      s_d.updCnt = '0;
    end else if (s_q.updActive) begin
      if (s_q.updCnt >= RelLast) begin
        s_d.updActive = 1'b0;
        s_d.updCnt = '0;
      end else begin
        s_d.updCnt = s_q.updCnt + CNT_W'(1);
      end
    end
    // The pin follows the next state so that a cancelling write takes effect at once.
    s_d.irqOeN = !((alarmFlagNext && alarmIrqEnNext) || s_d.updActive);
    if (regReq.rd) begin
      unique case (regReq.addr)
        ADDR_MINUTES: s_d.rdData = calNow.minutes;
        ADDR_HOURS: s_d.rdData = calNow.hours;
        ADDR_WEEKDAY: s_d.rdData = calNow.weekday;
        ADDR_DATE: s_d.rdData = calNow.date;
        ADDR_ALM_MIN: s_d.rdData = s_q.almMin;
        ADDR_ALM_HOUR: s_d.rdData = s_q.almHour;
        ADDR_ALM_DAY: s_d.rdData = s_q.almDay;
        ADDR_EXT_CFG: s_d.rdData = s_q.ext;
        ADDR_FLAGS: begin
          s_d.rdData = RD_UNMAPPED;
          s_d.rdData[FLAG_UPD_BIT] = s_q.updateFlag;
          s_d.rdData[FLAG_ALM_BIT] = s_q.alarmFlag;
        end
        ADDR_CTRL: s_d.rdData = s_q.ctrl;
        default: s_d.rdData = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{
        almMin: ALM_RESET,
        almHour: ALM_RESET,
        almDay: ALM_RESET,
        ext: EXT_RESET,
        ctrl: CTRL_RESET,
        irqOeN: 1'b1,
        rdData: RD_UNMAPPED,
        default: '0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign irqOut = 1'b0;
  assign irqOutEn_n = s_q.irqOeN;

  // Checks.
  alarm_flag_set_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    alarmEvt |=> s_q.alarmFlag
  ) else $error("alarm flag not set after alarm event");

  alarm_flag_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_q.alarmFlag && !(wrFlags && !regReq.wdata[FLAG_ALM_BIT])) |=> s_q.alarmFlag
  ) else $error("alarm flag dropped without a zero write");

  alarm_flag_clear_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (wrFlags && !regReq.wdata[FLAG_ALM_BIT] && !alarmEvt) |=> !s_q.alarmFlag
  ) else $error("alarm flag not cleared by a zero write");

  alarm_write_one_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_q.alarmFlag && wrFlags && regReq.wdata[FLAG_ALM_BIT]) |=> s_q.alarmFlag
  ) else $error("writing one changed the alarm flag");

  alarm_no_early_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!s_q.alarmFlag && !alarmEvt) |=> !s_q.alarmFlag
  ) else $error("alarm flag set without an advancing match");

  alarm_setup_quiet_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!calMoved && !s_q.alarmFlag) |=> !s_q.alarmFlag
  ) else $error("alarm raised without a calendar advance");

  alarm_pin_low_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (alarmEvt && s_q.ctrl[CTRL_ALM_IRQ_EN_BIT] && !wrCtrl) |=> !irqOutEn_n [*2]
  ) else $error("alarm did not hold the pin low");

  alarm_pin_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!irqOutEn_n && s_q.alarmFlag && s_q.ctrl[CTRL_ALM_IRQ_EN_BIT] && !wrCtrl && !wrFlags)
      |=> !irqOutEn_n
  ) else $error("alarm pin released by itself");

  alarm_en_release_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!irqOutEn_n && !s_q.updActive && (wrCtrl || wrFlags)
      && !(alarmFlagNext && alarmIrqEnNext) && !updEvt) |=> irqOutEn_n
  ) else $error("pin not released when alarm was cancelled");

  alarm_en_off_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_q.alarmFlag && !s_q.updActive && !updEvt && wrCtrl
      && !regReq.wdata[CTRL_ALM_IRQ_EN_BIT]) |=> irqOutEn_n
  ) else $error("pin held after alarm enable cleared");

  alarm_flag_off_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!s_q.updActive && !updEvt && !alarmEvt && wrFlags
      && !regReq.wdata[FLAG_ALM_BIT]) |=> irqOutEn_n
  ) else $error("pin held after alarm flag cleared");

  alarm_quiet_pin_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (alarmEvt && !alarmIrqEnNext && !s_d.updActive) |=> (s_q.alarmFlag && irqOutEn_n)
  ) else $error("disabled alarm event drove the pin");

  stop_no_event_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (stopped && !s_q.alarmFlag && !s_q.updateFlag) |=> (!s_q.alarmFlag && !s_q.updateFlag)
  ) else $error("event while stopped");

  date_target_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (calMoved && !stopped && s_q.ext[EXT_TARGET_BIT] && s_q.almMin[ALM_EXCLUDE_BIT]
      && (s_q.almHour[5:0] == calNow.hours[5:0]) && !s_q.almDay[ALM_EXCLUDE_BIT]
      && (s_q.almDay[5:0] == calNow.date[5:0])) |-> alarmEvt
  ) else $error("date target did not raise the alarm");

  day_mask_empty_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!s_q.ext[EXT_TARGET_BIT] && !s_q.almDay[ALM_EXCLUDE_BIT]
      && (s_q.almDay[6:0] == 7'h00)) |-> !alarmEvt
  ) else $error("alarm with an empty day mask");

  all_excluded_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (calMoved && !stopped && s_q.almMin[ALM_EXCLUDE_BIT] && s_q.almHour[ALM_EXCLUDE_BIT]
      && s_q.almDay[ALM_EXCLUDE_BIT]) |-> alarmEvt
  ) else $error("fully excluded alarm did not fire");

  pin_or_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    irqOutEn_n == !((s_q.alarmFlag && s_q.ctrl[CTRL_ALM_IRQ_EN_BIT]) || s_q.updActive)
  ) else $error("pin is not the OR of its sources");

  second_source_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!stopped && !s_q.ext[EXT_UPD_SEL_BIT] && secTick) |=> s_q.updateFlag
  ) else $error("second tick did not set the update flag");

  minute_source_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!stopped && s_q.ext[EXT_UPD_SEL_BIT] && minMoved) |=> s_q.updateFlag
  ) else $error("minute rollover did not set the update flag");

  minute_quiet_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_q.ext[EXT_UPD_SEL_BIT] && !minMoved && !s_q.updateFlag) |=> !s_q.updateFlag
  ) else $error("update flag set without a minute rollover");

  update_flag_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (updEvt && !s_q.ctrl[CTRL_UPD_IRQ_EN_BIT] && !wrCtrl) |=> (s_q.updateFlag && !s_q.updActive)
  ) else $error("update event did not set flag or drove pin while disabled");

  update_flag_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_q.updateFlag && !(wrFlags && !regReq.wdata[FLAG_UPD_BIT])) |=> s_q.updateFlag
  ) else $error("update flag dropped without a zero write");

  update_flag_clear_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (wrFlags && !regReq.wdata[FLAG_UPD_BIT] && !updEvt) |=> !s_q.updateFlag
  ) else $error("update flag not cleared by a zero write");

  update_start_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (updEvt && updateIrqEnNext) |=> (!irqOutEn_n && s_q.updActive && (s_q.updCnt == '0))
  ) else $error("enabled update event did not start a pulse");

  update_no_pin_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!s_q.ctrl[CTRL_UPD_IRQ_EN_BIT] && !wrCtrl) |=> !s_q.updActive
  ) else $error("update pulse while the update enable is clear");

  update_step_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_q.updActive && (s_q.updCnt < RelLast) && !updEvt && updateFlagNext && updateIrqEnNext)
      |=> (s_q.updActive && (s_q.updCnt == $past(s_q.updCnt) + CNT_W'(1)))
  ) else $error("update pulse counter did not advance");

  update_timeout_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    ($fell(s_q.updActive) && !$past(wrCtrl) && !$past(wrFlags))
      |-> ($past(s_q.updCnt) == RelLast)
  ) else $error("update pulse ended at the wrong time");

  update_cancel_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_q.updActive && !updEvt && (!updateFlagNext || !updateIrqEnNext)) |=> !s_q.updActive
  ) else $error("update pulse not cancelled");

endmodule
`default_nettype wire

// ---- verif/aui_host_model.sv ----
// Host side model: pulled-up interrupt wire and the timekeeping clock.
`timescale 1ns/1ps
`default_nettype none
module aui_host_model (
  input wire logic irqOut,
  input wire logic irqOutEn_n,
  output logic irqWire,
  output logic tkClock
);
  // The timekeeping clock runs free at a phase unrelated to the system clock.
  initial begin
    tkClock = 1'b0;
    #7;
    forever begin
      tkClock = ~tkClock;
      #80;
    end
  end

  // The pull-up returns the wire high whenever the device releases it.
  assign irqWire = irqOutEn_n ? 1'b1 : irqOut;
endmodule
`default_nettype wire

// ---- verif/alarm_and_update_interrupts_test.sv ----
// Self-checking bench for the alarm and update interrupt block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin badCount++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module alarm_and_update_interrupts_test;
  import aui_pkg::*;
  localparam int RelCyc = 20;
  logic clock, arst_n, tkClock, irqWire, irqOut, irqOutEn_n;
  aui_cal_t calNow;
  aui_reg_req_t regReq;
  logic [7:0] regRdData, rdv;
  logic [7:0] ra [5] = '{ADDR_ALM_MIN, ADDR_ALM_HOUR, ADDR_ALM_DAY, ADDR_EXT_CFG, ADDR_CTRL};
  logic [7:0] rm [5] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'h7a};
  int badCount = 0;
  int testsRun = 0;
  int n;

  aui_core #(.IrqReleaseCyc(RelCyc), .TkClockPerSec(8)) dut (.clock(clock), .arst_n(arst_n),
    .tkClock(tkClock), .calNow(calNow), .regReq(regReq), .regRdData(regRdData),
    .irqIn(irqWire), .irqOut(irqOut), .irqOutEn_n(irqOutEn_n));
  aui_host_model host (.irqOut(irqOut), .irqOutEn_n(irqOutEn_n), .irqWire(irqWire),
    .tkClock(tkClock));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regReq = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    regReq = '0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    regReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    regReq = '0;
    @(negedge clock);
    rdv = regRdData;
  endtask

  task automatic cal(input logic [7:0] m, input logic [7:0] w, input logic [7:0] d);
    @(negedge clock);
    calNow = '{m, 8'h07, w, d};
    repeat (3) @(negedge clock);
  endtask

  task automatic chkA(input logic af, input logic pin);
    rd(ADDR_FLAGS);
    `CHK("alarm flag", af, rdv[FLAG_ALM_BIT])
    `CHK("irq wire", pin, irqWire)
  endtask

  task automatic waitPin(input logic v);
    n = 0;
    while (irqWire !== v) begin
      @(negedge clock);
      n++;
      if (n > 2000) begin
        badCount++;
        $display("CHECK FAILED irq wire wait exp %b got %b", v, irqWire);
        end_of_test();
      end
    end
  endtask

  initial begin
    arst_n = 1'b0;
    regReq = '0;
    calNow = '{8'h30, 8'h07, 8'h02, 8'h14};
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK("reset value", 8'h00, rdv)
      wr(ra[i], 8'hff);
      rd(ra[i]);
      `CHK("stored value", rm[i], rdv)
      wr(ra[i], 8'h00);
    end
    wr(ADDR_MINUTES, 8'h55);
    rd(ADDR_MINUTES);
    `CHK("calendar mirror", 8'h30, rdv)
    rd(8'h05);
    `CHK("unmapped read", RD_UNMAPPED, rdv)
    wr(ADDR_ALM_MIN, 8'h30);
    wr(ADDR_ALM_HOUR, 8'h07);
    wr(ADDR_ALM_DAY, 8'h3e);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_FLAGS, 8'h00);
    chkA(1'b0, 1'b1);
    cal(8'h31, 8'h02, 8'h14);
    cal(8'h30, 8'h02, 8'h14);
    chkA(1'b1, 1'b0);
    wr(ADDR_CTRL, 8'h00);
    chkA(1'b1, 1'b1);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_FLAGS, 8'h08);
    chkA(1'b1, 1'b0);
    wr(ADDR_FLAGS, 8'h00);
    chkA(1'b0, 1'b1);
    cal(8'h31, 8'h01, 8'h14);
    cal(8'h30, 8'h01, 8'h14);
    chkA(1'b0, 1'b1);
    wr(ADDR_CTRL, 8'h00);
    cal(8'h31, 8'h02, 8'h14);
    cal(8'h30, 8'h02, 8'h14);
    chkA(1'b1, 1'b1);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_EXT_CFG, 8'h40);
    wr(ADDR_ALM_MIN, 8'h80);
    wr(ADDR_ALM_DAY, 8'h15);
    wr(ADDR_CTRL, 8'h08);
    cal(8'h45, 8'h01, 8'h15);
    chkA(1'b1, 1'b0);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_EXT_CFG, 8'h00);
    cal(8'h46, 8'h02, 8'h15);
    chkA(1'b0, 1'b1);
    wr(ADDR_ALM_HOUR, 8'h80);
    wr(ADDR_ALM_DAY, 8'h80);
    cal(8'h47, 8'h02, 8'h15);
    chkA(1'b1, 1'b0);
    wr(ADDR_CTRL, 8'h0a);
    wr(ADDR_FLAGS, 8'h00);
    cal(8'h48, 8'h02, 8'h15);
    repeat (400) @(negedge clock);
    rd(ADDR_FLAGS);
    `CHK("flags while stopped", 8'h00, rdv)
    wr(ADDR_CTRL, 8'h20);
    waitPin(1'b0);
    waitPin(1'b1);
    waitPin(1'b0);
    n = 0;
    while (irqWire === 1'b0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    `CHK("pulse length", RelCyc, n)
    rd(ADDR_FLAGS);
    `CHK("update flag", 1'b1, rdv[FLAG_UPD_BIT])
    waitPin(1'b0);
    wr(ADDR_FLAGS, 8'h00);
    @(negedge clock);
    `CHK("irq wire after flag clear", 1'b1, irqWire)
    waitPin(1'b0);
    wr(ADDR_CTRL, 8'h00);
    @(negedge clock);
    `CHK("irq wire after enable clear", 1'b1, irqWire)
    wr(ADDR_FLAGS, 8'h00);
    repeat (400) @(negedge clock);
    rd(ADDR_FLAGS);
    `CHK("update flag no enable", 1'b1, rdv[FLAG_UPD_BIT])
    `CHK("irq wire no enable", 1'b1, irqWire)
    wr(ADDR_EXT_CFG, 8'h20);
    wr(ADDR_FLAGS, 8'h00);
    repeat (400) @(negedge clock);
    rd(ADDR_FLAGS);
    `CHK("flags minute mode idle", 8'h00, rdv)
    cal(8'h49, 8'h02, 8'h15);
    rd(ADDR_FLAGS);
    `CHK("minute update flag", 1'b1, rdv[FLAG_UPD_BIT])
    wr(ADDR_CTRL, 8'h20);
    cal(8'h4a, 8'h02, 8'h15);
    `CHK("irq wire update with alarm off", 1'b0, irqWire)
    repeat (RelCyc + 4) @(negedge clock);
    `CHK("irq wire after pulse with alarm flag", 1'b1, irqWire)
    end_of_test();
  end
endmodule
`default_nettype wire
